// ### verilog/swr_top.sv
// Supervisor: supply monitor, debounced manual reset, watchdog and reset stretcher
`timescale 1ns/1ps
module swr_top #(
  parameter int TICK_CYCLES = swr_pkg::TICK_CYCLES,
  parameter int STRETCH_MS = swr_pkg::STRETCH_MS,
  parameter int DEBOUNCE_MS = swr_pkg::MANUAL_DEBOUNCE_MS,
  parameter int WD_GND_MS = swr_pkg::WD_PERIOD_GND_MS,
  parameter int WD_OPEN_MS = swr_pkg::WD_PERIOD_OPEN_MS,
  parameter int WD_VCC_MS = swr_pkg::WD_PERIOD_VCC_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic supply_low_i,
  input wire logic manual_reset_n_i,
  input wire logic watchdog_strobe_n_i,
  input wire logic trip_tolerance_select_i,
  input wire logic [1:0] timeout_select_i,
  output logic trip_tolerance_o,
  output logic reset_o,
  output logic reset_n_o
);
  localparam int SUPPLY_BOUND = swr_pkg::SUPPLY_FAIL_DELAY_CYCLES;

  // Refuse settings the counters cannot hold or that break the timing floor
  if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << swr_pkg::TICK_CNT_W)) begin : g_chk_tick
    $error("swr_top: TICK_CYCLES out of range");
  end
  if (STRETCH_MS < 2 || DEBOUNCE_MS < 1 || DEBOUNCE_MS >= swr_pkg::MANUAL_LOW_MIN_TIME_MS) begin : g_chk_ms
    $error("swr_top: stretch or debounce count out of range");
  end
  if (WD_VCC_MS >= (1 << swr_pkg::MS_CNT_W) || STRETCH_MS >= (1 << swr_pkg::MS_CNT_W)) begin : g_chk_w
    $error("swr_top: millisecond count too wide");
  end
  if (WD_GND_MS < 2 || WD_OPEN_MS < 2 || WD_VCC_MS < 2) begin : g_chk_wd
    $error("swr_top: watchdog period too short");
  end

  logic [swr_pkg::PIN_W-1:0] pins;
  logic [swr_pkg::PIN_W-1:0] pins_s;
  logic supply_low_s;
  logic manual_n_s;
  logic strobe_n_s;
  logic tol_s;
  logic [1:0] tsel_s;
  logic [swr_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic tick_reg;
  logic [swr_pkg::MS_CNT_W-1:0] deb_cnt_reg;
  logic manual_active_reg;
  logic strobe_prev_reg;
  logic strobe_fall;
  logic [swr_pkg::MS_CNT_W-1:0] wd_cnt_reg;
  logic [swr_pkg::MS_CNT_W-1:0] wd_limit;
  logic wd_fire;
  logic cause;
  logic rst_active_reg;
  logic [swr_pkg::MS_CNT_W-1:0] stretch_cnt_reg;

  // Watchdog period for a given timeout select code
  function automatic logic [swr_pkg::MS_CNT_W-1:0] wd_period(input logic [1:0] sel);
    case (sel)
      swr_pkg::TSEL_GND: wd_period = swr_pkg::MS_CNT_W'(WD_GND_MS);
      swr_pkg::TSEL_OPEN: wd_period = swr_pkg::MS_CNT_W'(WD_OPEN_MS);
      default: wd_period = swr_pkg::MS_CNT_W'(WD_VCC_MS);
    endcase
  endfunction

  // All pins pass the three-stage synchroniser
  assign pins = {timeout_select_i, trip_tolerance_select_i, watchdog_strobe_n_i, manual_reset_n_i, supply_low_i};
  swr_pin_sync #(
    .W(swr_pkg::PIN_W),
    .RST_VAL(swr_pkg::PIN_RST_VAL)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pins),
    .sync_o(pins_s)
  );
  assign supply_low_s = pins_s[swr_pkg::PIN_SUPPLY_LOW];
  assign manual_n_s = pins_s[swr_pkg::PIN_MANUAL_N];
  assign strobe_n_s = pins_s[swr_pkg::PIN_STROBE_N];
  assign tol_s = pins_s[swr_pkg::PIN_TOL];
  assign tsel_s = pins_s[swr_pkg::PIN_TSEL_LO +: 2];

  // Tolerance choice handed to the supply comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_tolerance_o <= 1'b0;
    end else begin
      trip_tolerance_o <= tol_s;
    end
  end

  // Free-running millisecond time base
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == swr_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // Manual input debounce: active after a stable low of DEBOUNCE_MS ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deb_cnt_reg <= '0;
      manual_active_reg <= 1'b0;
    end else if (manual_n_s) begin
      deb_cnt_reg <= '0;
      manual_active_reg <= 1'b0;
    end else if (deb_cnt_reg == swr_pkg::MS_CNT_W'(DEBOUNCE_MS)) begin
      manual_active_reg <= 1'b1;
    end else if (tick_reg) begin
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
    end
  end

  // Strobe edge detector on the agreed synchroniser output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_prev_reg <= 1'b1;
    end else begin
      strobe_prev_reg <= strobe_n_s;
    end
  end
  assign strobe_fall = strobe_prev_reg & ~strobe_n_s;

  // Watchdog: no enable exists; held at zero while reset is active
  assign wd_limit = wd_period(tsel_s);
  assign wd_fire = !rst_active_reg && (wd_cnt_reg >= wd_limit);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt_reg <= '0;
    end else if (rst_active_reg) begin
      wd_cnt_reg <= '0;
    end else if (strobe_fall) begin
      wd_cnt_reg <= '0;
    end else if (tick_reg && !wd_fire) begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  // Any live cause holds reset and reloads the stretch
  assign cause = supply_low_s | manual_active_reg | wd_fire;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_active_reg <= 1'b1;
      stretch_cnt_reg <= '0;
    end else if (cause) begin
      rst_active_reg <= 1'b1;
      stretch_cnt_reg <= '0;
    end else if (rst_active_reg) begin
      if (stretch_cnt_reg == swr_pkg::MS_CNT_W'(STRETCH_MS)) begin
        rst_active_reg <= 1'b0;
      end else if (tick_reg) begin
        stretch_cnt_reg <= stretch_cnt_reg + 1'b1;
      end
    end
  end

  // Complementary outputs, each its own flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_o <= 1'b1;
      reset_n_o <= 1'b0;
    end else begin
      reset_o <= cause | rst_active_reg;
      reset_n_o <= ~(cause | rst_active_reg);
    end
  end

  // Checks
  // Release edge: no cause at the deciding edge, then the outputs follow only a fresh cause
  sequence s_quiet_release;
    !$past(cause) ##1 (reset_o == $past(cause));
  endsequence

  a_outputs_complement: assert property (@(posedge clk_i) disable iff (rst_i) reset_o == !reset_n_o)
    else $error("reset outputs not complementary");
  a_supply_fail_fast: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(supply_low_s) |-> ##[1:SUPPLY_BOUND] reset_o)
    else $error("undervoltage did not assert reset in time");
  a_supply_holds: assert property (@(posedge clk_i) disable iff (rst_i) supply_low_s |=> reset_o)
    else $error("reset released while supply low");
  a_release_stretch: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(reset_o) |-> $past(stretch_cnt_reg) == swr_pkg::MS_CNT_W'(STRETCH_MS))
    else $error("reset released before stretch done");
  a_release_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_active_reg) |-> s_quiet_release)
    else $error("reset released with a live cause");
  a_manual_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(manual_active_reg) |-> !$past(manual_n_s) ##1 reset_o)
    else $error("manual reset not applied");
  a_wd_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
    wd_fire |=> reset_o && rst_active_reg)
    else $error("watchdog expiry did not reset");
  a_strobe_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    rst_active_reg |=> wd_cnt_reg == '0)
    else $error("watchdog counted during reset");
  a_strobe_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (!strobe_n_s && !strobe_prev_reg && tick_reg && !rst_active_reg && !wd_fire)
      |=> wd_cnt_reg == $past(wd_cnt_reg) + 1'b1)
    else $error("static strobe low restarted the period");
  a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i) tick_reg |=> !tick_reg)
    else $error("time base tick longer than one cycle");
  a_tol_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(tol_s) |=> trip_tolerance_o == $past(tol_s))
    else $error("tolerance select not passed on");

  // Release, restart and reload details
  a_release_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(reset_o) |-> !$past(supply_low_s) && !$past(manual_active_reg))
    else $error("reset released while a cause was live");
  a_manual_debounce: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(manual_active_reg) |-> $past(deb_cnt_reg) == swr_pkg::MS_CNT_W'(DEBOUNCE_MS))
    else $error("manual reset taken before debounce count");
  a_wd_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_active_reg) |-> wd_cnt_reg == '0)
    else $error("watchdog period not restarted at release");
  a_stretch_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    cause |=> stretch_cnt_reg == '0 && reset_o)
    else $error("live cause did not reload the stretch");
  a_tick_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_reg |-> tick_cnt_reg == '0)
    else $error("time base tick out of phase with its counter");
endmodule

// ### pkg/swr_pkg.sv
// Constants shared by the supervisor, watchdog and reset generator
// What this block does
// - Both reset outputs active during power-up and while supply is below trip level.
// - After supply recovers, outputs stay active at least 250 ms.
// - Supply recovery release happens between 250 and 1000 ms, typically 600 ms.
// - Undervoltage drives the reset outputs active within 8 us.
// - Tolerance select picks 5% when low, 10% when high, passed to comparator.
// - One active-high and one active-low reset output, same causes.
// - Debounced low manual input resets; outputs hold at least 250 ms after release.
// - Outputs go active within 20 ms of manual input stably low.
// - Timeout select gives 150, 600 or 1200 ms for ground, open, supply.
// - Missing strobe before period end resets for at least 250 ms.
// - Watchdog cannot be disabled; only strobing prevents its reset.
// - Only a high-to-low strobe edge restarts the period.
// - Strobe ignored while reset is active.
// - Watchdog period restarts from zero when reset outputs release.
package swr_pkg;
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  // Time base: one tick per millisecond
  localparam int TIME_BASE_US = 1000;
  localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * TIME_BASE_US;
  // Millisecond figures, counted in ticks
  localparam int STRETCH_MIN_MS = 250;
  localparam int STRETCH_MS = 600;
  localparam int MANUAL_LOW_MIN_TIME_MS = 20;
  localparam int MANUAL_DEBOUNCE_MS = 10;
  localparam int WD_PERIOD_GND_MS = 150;
  localparam int WD_PERIOD_OPEN_MS = 600;
  localparam int WD_PERIOD_VCC_MS = 1200;
  // Supply fail to reset delay, longest
  localparam int SUPPLY_FAIL_DELAY_NS = 8000;
  localparam int SUPPLY_FAIL_DELAY_CYCLES = SUPPLY_FAIL_DELAY_NS / CLK_PERIOD_NS;
  // Counter widths
  localparam int MS_CNT_W = 12;
  localparam int TICK_CNT_W = 24;
  // Timeout select encodings
  localparam logic [1:0] TSEL_GND = 2'h0;
  localparam logic [1:0] TSEL_OPEN = 2'h1;
  localparam logic [1:0] TSEL_VCC = 2'h2;
  // Pin synchroniser layout and reset values
  localparam int PIN_W = 6;
  localparam int PIN_SUPPLY_LOW = 0;
  localparam int PIN_MANUAL_N = 1;
  localparam int PIN_STROBE_N = 2;
  localparam int PIN_TOL = 3;
  localparam int PIN_TSEL_LO = 4;
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 6'h07;
endpackage

// ### verilog/swr_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module swr_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff1_reg <= RST_VAL;
      ff2_reg <= RST_VAL;
      ff3_reg <= RST_VAL;
    end else begin
      ff1_reg <= pin_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // Output bit follows only when the last two stages match
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync_o[i] <= RST_VAL[i];
      end else if (ff2_reg[i] == ff3_reg[i]) begin
        sync_o[i] <= ff3_reg[i];
      end
    end
  end
endmodule

// ### bench/swr_host_model.sv
// Host model: strobes the watchdog on a fixed interval, or holds the strobe idle or low
`timescale 1ns/1ps
module swr_host_model #(
  parameter int INTERVAL = 30,
  parameter int PULSE = 4
) (
  input wire logic clk_i,
  input wire logic [1:0] mode_i,
  output logic strobe_n_o
);
  int cnt = 0;
  initial strobe_n_o = 1'b1;
  // Mode 0 idle high, 1 periodic low pulse, 2 static low; pulse far shorter than any period
  always @(posedge clk_i) begin
    cnt <= (cnt >= INTERVAL - 1) ? 0 : cnt + 1;
    if (mode_i == 2'h2) begin
      strobe_n_o <= #2 1'b0;
    end else if (mode_i == 2'h1) begin
      strobe_n_o <= #2 (cnt >= PULSE);
    end else begin
      strobe_n_o <= #2 1'b1;
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking bench for the supervisor: supply, manual, watchdog and release timing
`timescale 1ns/1ps
module tb;
  localparam int TICK = 10;
  localparam int STR = 4;
  localparam int DEB = 2;
  localparam int WD_G = 6;
  localparam int WD_O = 10;
  localparam int WD_V = 16;
  localparam int REL_LO = (STR - 1) * TICK;
  localparam int REL_HI = STR * TICK + 8;
  localparam int MAN_MIN = 20; // Scaled minimum press time in ticks
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_low_i = 1'b1;
  logic manual_reset_n_i = 1'b1;
  logic trip_tolerance_select_i = 1'b0;
  logic [1:0] timeout_select_i = 2'h0;
  logic [1:0] host_mode = 2'h1;
  logic watchdog_strobe_n_i;
  logic trip_tolerance_o;
  logic reset_o;
  logic reset_n_o;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  int wd_tab[4] = '{WD_G, WD_O, WD_V, WD_V};
  always #20 clk_i = ~clk_i;
  swr_top #(.TICK_CYCLES(TICK), .STRETCH_MS(STR), .DEBOUNCE_MS(DEB), .WD_GND_MS(WD_G), .WD_OPEN_MS(WD_O),
    .WD_VCC_MS(WD_V)) u_swr_top (.clk_i(clk_i), .rst_i(rst_i), .supply_low_i(supply_low_i),
    .manual_reset_n_i(manual_reset_n_i), .watchdog_strobe_n_i(watchdog_strobe_n_i),
    .trip_tolerance_select_i(trip_tolerance_select_i), .timeout_select_i(timeout_select_i),
    .trip_tolerance_o(trip_tolerance_o), .reset_o(reset_o), .reset_n_o(reset_n_o));
  swr_host_model u_swr_host_model (.clk_i(clk_i), .mode_i(host_mode), .strobe_n_o(watchdog_strobe_n_i));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic in_range(input string name, input int v, input int lo, input int hi);
    check(name, {31'h00000000, (v >= lo && v <= hi)}, 32'h00000001);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask
  // Waits for reset_o to reach a level, counting cycles up to a limit
  task automatic wait_level(input logic lvl, input int limit, output int cnt);
    cnt = 0;
    while (reset_o !== lvl && cnt < limit) begin
      step(1);
      cnt++;
    end
  endtask
  // Both outputs always opposite, sampled away from the active edge
  always @(negedge clk_i) begin
    check("reset_n_o", {31'h00000000, reset_n_o}, {31'h00000000, ~reset_o});
  end
  task automatic t_power_up;
    step(20);
    check("reset_o power-up", {31'h00000000, reset_o}, 32'h00000001);
    supply_low_i = 1'b0;
    wait_level(1'b0, 200, n);
    in_range("power-up release", n, REL_LO, REL_HI);
  endtask
  task automatic t_supply;
    for (int t = 0; t < 2; t++) begin
      trip_tolerance_select_i = t[0];
      step(8);
      check("trip_tolerance_o", {31'h00000000, trip_tolerance_o}, t);
      supply_low_i = 1'b1;
      wait_level(1'b1, 300, n);
      in_range("supply fail delay", n, 0, 200);
      step(60);
      check("reset_o supply low", {31'h00000000, reset_o}, 32'h00000001);
      supply_low_i = 1'b0;
      wait_level(1'b0, 200, n);
      in_range("supply release", n, REL_LO, REL_HI);
    end
  endtask
  task automatic t_manual;
    manual_reset_n_i = 1'b0;
    step(5);
    manual_reset_n_i = 1'b1;
    wait_level(1'b1, 60, n);
    check("short press ignored", n, 60);
    manual_reset_n_i = 1'b0;
    wait_level(1'b1, 200, n);
    in_range("manual assert delay", n, (DEB - 1) * TICK, (DEB + 1) * TICK + 8);
    // Press stays down past the scaled minimum press time
    step(MAN_MIN * TICK);
    check("reset_o manual held", {31'h00000000, reset_o}, 32'h00000001);
    manual_reset_n_i = 1'b1;
    wait_level(1'b0, 200, n);
    in_range("manual release", n, REL_LO, REL_HI);
  endtask
  task automatic t_watchdog;
    host_mode = 2'h0;
    for (int s = 0; s < 4; s++) begin
      timeout_select_i = s[1:0];
      wait_level(1'b1, wd_tab[s] * TICK + 40, n);
      in_range("watchdog period", n, (wd_tab[s] - 1) * TICK, wd_tab[s] * TICK + 8);
      wait_level(1'b0, 200, n);
      in_range("watchdog stretch", n, REL_LO, REL_HI);
    end
    host_mode = 2'h2;
    wait_level(1'b1, (WD_V + 1) * TICK + 20, n);
    check("static low no restart", {31'h00000000, reset_o}, 32'h00000001);
    host_mode = 2'h1;
    wait_level(1'b0, 200, n);
    wait_level(1'b1, 3 * WD_V * TICK, n);
    check("strobed no reset", n, 3 * WD_V * TICK);
  endtask
  task automatic test_done;
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    t_power_up();
    t_supply();
    t_manual();
    t_watchdog();
    test_done();
  end
endmodule
